// >>> design/scr_backend.sv
// scratchpad ram backend: shared array module on the instruction-side port with backdoor
`timescale 1ns/1ps
`default_nettype none

module scr_backend (
    input wire logic i_clk,                       // core clock
    input wire logic i_rstn,                      // async reset, active low
    input wire logic i_hsel,                      // ahb slave select
    input wire logic [31:0] i_haddr,              // ahb address
    input wire logic [1:0] i_htrans,              // ahb transfer type
    input wire logic i_hwrite,                    // ahb write
    input wire logic [2:0] i_hsize,               // ahb size, word only
    input wire logic [31:0] i_hwdata,             // ahb write data
    input wire logic i_hready,                    // ahb bus ready
    output logic [31:0] o_hrdata,                 // ahb read data
    output logic o_hreadyout,                     // ahb slave ready
    output logic [1:0] o_hresp,                   // ahb response
    input wire logic [19:2] i_iside_index,        // instruction-side index
    input wire logic i_iside_read_strobe,         // tag and data read
    input wire logic i_iside_data_write_strobe,   // data write
    input wire logic i_iside_tag_write_strobe,    // tag write
    input wire logic [31:0] i_iside_combined_value, // compare value or write data
    output logic o_iside_hold_request,            // stall toward core
    output logic o_iside_hit,                     // hit for pending read
    output logic [31:0] o_iside_read_data,        // read word
    output logic [3:0] o_iside_read_parity,       // per-byte even parity
    output logic [23:0] o_iside_tag_read_value,   // configuration tag value
    output logic o_iside_parity_present           // array is parity protected
);
    logic [31:0] mem [scr_pkg::WORDS];
    logic [3:0] par_mem [scr_pkg::WORDS];

    function automatic logic [3:0] byte_parity(input logic [31:0] w);
        logic [3:0] p;
        p = '0;
        for (int b = 0; b < 4; b++) begin
            p[b] = ^w[8*b +: 8];
        end
        return p;
    endfunction

    // one contiguous region, so no hole entries are ever produced
    function automatic logic [23:0] cfg_tag(input logic [15:0] line, input logic [19:0] base,
                                            input logic en);
        logic [23:0] t;
        t = 24'h000000;
        if (line == scr_pkg::TAG_BASE_IDX) begin
            t = {base, 2'h0, 1'b0, en};
        end else if (line == scr_pkg::TAG_SIZE_IDX) begin
            t = {scr_pkg::REGION_LINES, 2'h0};
        end else begin
            t = 24'h000000;
        end
        return t;
    endfunction

    // register state
    logic [1:0] ctrl, next_ctrl;
    logic [19:0] base, next_base;
    logic [scr_pkg::AW-1:0] bd_addr, next_bd_addr;
    logic [31:0] bd_wdata, next_bd_wdata;
    logic [31:0] bd_rdata, next_bd_rdata;
    logic bd_wr, next_bd_wr;
    logic bd_done, next_bd_done;
    scr_pkg::scr_bd_e bd_state, next_bd_state;
    logic a_wr, next_a_wr;
    logic a_sel, next_a_sel;
    logic [7:0] a_off, next_a_off;
    logic [31:0] hrdata, next_hrdata;

    // core-side pending transaction
    logic p_rd, next_p_rd;
    logic p_wr, next_p_wr;
    logic p_tw, next_p_tw;
    logic [19:2] p_idx, next_p_idx;
    logic [31:0] p_wdata, next_p_wdata;
    logic [31:0] rdata, next_rdata;
    logic [3:0] rpar, next_rpar;
    logic [23:0] tagval, next_tagval;

    logic pending, stall, take, core_wr_en, bd_wr_en;
    logic [19:2] look_idx;
    logic [17:0] word_index;
    logic [15:0] line_index;
    logic [3:0] wr_mask;

    assign pending = p_rd | p_wr | p_tw;
    // a backdoor cycle plus one settle cycle so the re-read sees fresh data
    assign stall = pending && (bd_state != scr_pkg::SCR_BD_IDLE);
    assign core_wr_en = p_wr && !stall;
    assign bd_wr_en = (bd_state == scr_pkg::SCR_BD_SERVE) && bd_wr;
    assign look_idx = stall ? p_idx : i_iside_index;
    assign word_index = look_idx[19:2];
    assign line_index = look_idx[19:4];
    assign wr_mask = scr_pkg::BYTE_MASK_ALL;
    assign take = i_hsel && (i_htrans == scr_pkg::HTRANS_NONSEQ) && i_hready;

    assign o_hrdata = hrdata;
    assign o_hreadyout = 1'b1;
    assign o_hresp = scr_pkg::HRESP_OKAY;
    assign o_iside_hold_request = stall;
    // physical address arrives on the compare bus the cycle after the index
    assign o_iside_hit = p_rd && ctrl[scr_pkg::CTRL_EN_BIT]
                         && (i_iside_combined_value[23:4] == base);
    assign o_iside_read_data = rdata;
    assign o_iside_read_parity = rpar;
    assign o_iside_tag_read_value = tagval;
    assign o_iside_parity_present = ctrl[scr_pkg::CTRL_PAR_BIT];

    always_comb begin
        next_ctrl = ctrl;
        next_base = base;
        next_bd_addr = bd_addr;
        next_bd_wdata = bd_wdata;
        next_bd_rdata = bd_rdata;
        next_bd_wr = bd_wr;
        next_bd_done = bd_done;
        next_bd_state = bd_state;
        next_a_wr = take && i_hwrite;
        next_a_sel = take;
        next_a_off = take ? i_haddr[7:0] : a_off;
        next_hrdata = hrdata;
        if (a_sel && a_wr) begin
            case (a_off)
                scr_pkg::OFF_CTRL: begin
                    next_ctrl = i_hwdata[1:0];
                end
                scr_pkg::OFF_BASE: begin
                    next_base = i_hwdata[31:12];
                end
                scr_pkg::OFF_BD_ADDR: begin
                    next_bd_addr = i_hwdata[scr_pkg::AW+1:2];
                end
                scr_pkg::OFF_BD_WDATA: begin
                    next_bd_wdata = i_hwdata;
                end
                scr_pkg::OFF_BD_CMD: begin
                    // a command while busy is dropped, software polls busy first
                    if (i_hwdata[scr_pkg::CMD_GO_BIT] && bd_state == scr_pkg::SCR_BD_IDLE) begin
                        next_bd_state = scr_pkg::SCR_BD_SERVE;
                        next_bd_wr = i_hwdata[scr_pkg::CMD_WR_BIT];
                        next_bd_done = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        case (bd_state)
            scr_pkg::SCR_BD_SERVE: begin
                next_bd_rdata = mem[bd_addr];
                next_bd_state = scr_pkg::SCR_BD_SETTLE;
            end
            scr_pkg::SCR_BD_SETTLE: begin
                next_bd_state = scr_pkg::SCR_BD_IDLE;
                next_bd_done = 1'b1;
            end
            default: begin
            end
        endcase
        if (take && !i_hwrite) begin
            case (i_haddr[7:0])
                scr_pkg::OFF_CTRL: next_hrdata = {30'h0, ctrl};
                scr_pkg::OFF_BASE: next_hrdata = {base, 12'h000};
                scr_pkg::OFF_BD_ADDR: next_hrdata = {20'h0, bd_addr, 2'h0};
                scr_pkg::OFF_BD_WDATA: next_hrdata = bd_wdata;
                scr_pkg::OFF_BD_RDATA: next_hrdata = bd_rdata;
                scr_pkg::OFF_STATUS: next_hrdata = {29'h0, stall, bd_done,
                                                    bd_state != scr_pkg::SCR_BD_IDLE};
                default: next_hrdata = 32'h00000000;
            endcase
        end
    end

    always_comb begin
        next_p_rd = p_rd;
        next_p_wr = p_wr;
        next_p_tw = p_tw;
        next_p_idx = p_idx;
        next_p_wdata = p_wdata;
        if (!stall) begin
            next_p_rd = i_iside_read_strobe;
            next_p_wr = i_iside_data_write_strobe;
            next_p_tw = i_iside_tag_write_strobe;
            next_p_idx = i_iside_index;
            next_p_wdata = i_iside_combined_value;
        end
        next_rdata = mem[word_index[scr_pkg::AW-1:0]];
        next_rpar = par_mem[word_index[scr_pkg::AW-1:0]];
        // forward a completing write so a read right behind it sees the new word
        if (core_wr_en && p_idx[scr_pkg::AW+1:2] == word_index[scr_pkg::AW-1:0]) begin
            next_rdata = p_wdata;
            next_rpar = byte_parity(p_wdata);
        end
        next_tagval = cfg_tag(line_index, base, ctrl[scr_pkg::CTRL_EN_BIT]);
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl <= scr_pkg::CTRL_RESET;
            base <= scr_pkg::BASE_RESET;
            bd_addr <= '0;
            bd_wdata <= 32'h00000000;
            bd_rdata <= 32'h00000000;
            bd_wr <= 1'b0;
            bd_done <= 1'b0;
            bd_state <= scr_pkg::SCR_BD_IDLE;
            a_wr <= 1'b0;
            a_sel <= 1'b0;
            a_off <= 8'h00;
            hrdata <= 32'h00000000;
            p_rd <= 1'b0;
            p_wr <= 1'b0;
            p_tw <= 1'b0;
            p_idx <= '0;
            p_wdata <= 32'h00000000;
            rdata <= 32'h00000000;
            rpar <= 4'h0;
            tagval <= 24'h000000;
        end else begin
            ctrl <= next_ctrl;
            base <= next_base;
            bd_addr <= next_bd_addr;
            bd_wdata <= next_bd_wdata;
            bd_rdata <= next_bd_rdata;
            bd_wr <= next_bd_wr;
            bd_done <= next_bd_done;
            bd_state <= next_bd_state;
            a_wr <= next_a_wr;
            a_sel <= next_a_sel;
            a_off <= next_a_off;
            hrdata <= next_hrdata;
            p_rd <= next_p_rd;
            p_wr <= next_p_wr;
            p_tw <= next_p_tw;
            p_idx <= next_p_idx;
            p_wdata <= next_p_wdata;
            rdata <= next_rdata;
            rpar <= next_rpar;
            tagval <= next_tagval;
        end
    end

    // single write port on the array: backdoor and core never write in the same cycle
    always_ff @(posedge i_clk) begin
        if (bd_wr_en) begin
            mem[bd_addr] <= bd_wdata;
            par_mem[bd_addr] <= byte_parity(bd_wdata);
        end else if (core_wr_en && wr_mask == scr_pkg::BYTE_MASK_ALL) begin
            mem[p_idx[scr_pkg::AW+1:2]] <= p_wdata;
            par_mem[p_idx[scr_pkg::AW+1:2]] <= byte_parity(p_wdata);
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    arb_stall_a: assert property (
        pending && bd_state == scr_pkg::SCR_BD_SERVE |-> stall)
        else $error("core not stalled against backdoor");
    no_stall_a: assert property (
        bd_state == scr_pkg::SCR_BD_IDLE |-> !o_iside_hold_request)
        else $error("stall without backdoor");
    index_capture_a: assert property (
        i_iside_read_strobe && !stall |=> p_idx == $past(i_iside_index))
        else $error("index not captured");
    both_read_a: assert property (
        i_iside_read_strobe && !stall |=> p_rd
        && tagval == cfg_tag($past(i_iside_index[19:4]), $past(base), $past(ctrl[0])))
        else $error("tag and data not read together");
    base_entry_a: assert property (
        i_iside_read_strobe && !stall && i_iside_index[19:4] == 16'h0000
        |=> tagval == {$past(base), 2'h0, 1'b0, $past(ctrl[0])})
        else $error("base entry wrong");
    size_entry_a: assert property (
        i_iside_read_strobe && !stall && i_iside_index[19:4] == 16'h0001
        |=> tagval == 24'h000400)
        else $error("size entry wrong");
    list_end_a: assert property (
        i_iside_read_strobe && !stall && i_iside_index[19:4] == 16'h0002
        |=> tagval[23:2] == 22'h0)
        else $error("list not terminated");
    full_write_a: assert property (
        core_wr_en |=> mem[$past(p_idx[11:2])] == $past(p_wdata))
        else $error("word write incomplete");
    stall_bound_a: assert property (stall |-> ##[1:2] !stall)
        else $error("stall too long");
    bd_excl_a: assert property (bd_state == scr_pkg::SCR_BD_SERVE |-> !core_wr_en)
        else $error("core wrote during backdoor");
    parity_flag_a: assert property (o_iside_parity_present == ctrl[1])
        else $error("parity present mismatch");
    hit_a: assert property (
        p_rd && ctrl[0] && i_iside_combined_value[23:4] == base |-> o_iside_hit)
        else $error("hit missed");

    stall_c: cover property (stall ##1 stall ##1 !stall);
    bd_write_c: cover property (bd_wr_en);
    hit_c: cover property (o_iside_hit && !stall);
    fwd_c: cover property (core_wr_en && i_iside_read_strobe);
endmodule

`default_nettype wire

// >>> shared/scr_pkg.sv
// constants for the scratchpad ram backend: register map, fields, array geometry
package scr_pkg;
    localparam int unsigned WORDS = 1024;
    localparam int unsigned AW = 10;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_BASE = 8'h04;
    localparam logic [7:0] OFF_BD_ADDR = 8'h08;
    localparam logic [7:0] OFF_BD_WDATA = 8'h0C;
    localparam logic [7:0] OFF_BD_CMD = 8'h10;
    localparam logic [7:0] OFF_BD_RDATA = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned CTRL_PAR_BIT = 1;
    localparam int unsigned CMD_GO_BIT = 0;
    localparam int unsigned CMD_WR_BIT = 1;
    localparam int unsigned ST_BUSY_BIT = 0;
    localparam int unsigned ST_DONE_BIT = 1;
    localparam int unsigned ST_STALL_BIT = 2;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [19:0] BASE_RESET = 20'h00000;
    localparam logic [21:0] REGION_LINES = 22'h000100;
    localparam logic [3:0] BYTE_MASK_ALL = 4'hF;
    localparam logic [15:0] TAG_BASE_IDX = 16'h0000;
    localparam logic [15:0] TAG_SIZE_IDX = 16'h0001;
    localparam logic [15:0] TAG_END_BASE_IDX = 16'h0002;
    localparam logic [15:0] TAG_END_SIZE_IDX = 16'h0003;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;
    typedef enum logic [1:0] {SCR_BD_IDLE, SCR_BD_SERVE, SCR_BD_SETTLE} scr_bd_e;
endpackage

// >>> bench/scr_core_model.sv
// core-side model of the instruction scratchpad port
`timescale 1ns/1ps
`default_nettype none
module scr_core_model (
    input wire logic i_clk,            // core clock
    input wire logic i_rstn,           // reset, active low
    input wire logic i_go,             // access wanted
    input wire logic [1:0] i_kind,     // 0 read, 1 data write, 2 tag write
    input wire logic [19:2] i_idx,     // word index
    input wire logic [31:0] i_val,     // write data or physical address
    input wire logic i_hold,           // stall from block
    input wire logic i_hit,            // hit from block
    input wire logic [31:0] i_rdata,   // read word
    input wire logic [3:0] i_rpar,     // read parity
    input wire logic [23:0] i_rtag,    // tag read value
    input wire logic i_par_present,    // parity present
    output logic [19:2] o_index,       // index to block
    output logic o_rd,                 // read strobe
    output logic o_dwr,                // data write strobe
    output logic o_twr,                // tag write strobe
    output logic [31:0] o_value,       // combined value
    output logic o_busy,               // access in flight
    output logic o_hit,                // captured hit
    output logic [31:0] o_data,        // captured word
    output logic [23:0] o_tag,         // captured tag value
    output logic o_par_err             // parity fault seen
);
    logic [1:0] phase;
    logic [1:0] kind_q;
    logic [31:0] pa;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            phase <= 2'h0;
            o_rd <= 1'b0;
            o_dwr <= 1'b0;
            o_twr <= 1'b0;
            o_busy <= 1'b0;
            o_par_err <= 1'b0;
            o_index <= 18'h0;
            o_value <= 32'h5A5A_A5A5;
            o_hit <= 1'b0;
            o_data <= 32'h0;
            o_tag <= 24'h0;
            pa <= 32'h0;
            kind_q <= 2'h0;
        end else begin
            o_rd <= 1'b0;
            o_dwr <= 1'b0;
            o_twr <= 1'b0;
            if (phase == 2'h0 && i_go && !i_hold) begin
                o_index <= i_idx;
                o_rd <= (i_kind == 2'h0);
                o_dwr <= (i_kind == 2'h1);
                o_twr <= (i_kind == 2'h2);
                // a read shows no meaningful value yet, so the bus toggles
                o_value <= (i_kind == 2'h0) ? ~o_value : i_val;
                pa <= i_val;
                kind_q <= i_kind;
                o_busy <= 1'b1;
                phase <= 2'h1;
            end else if (phase == 2'h1) begin
                if (kind_q == 2'h0) o_value <= {8'h00, pa[31:8]};
                phase <= 2'h2;
            end else if (phase == 2'h2 && !i_hold) begin
                o_hit <= i_hit;
                o_data <= i_rdata;
                o_tag <= i_rtag;
                o_par_err <= o_par_err | (i_par_present && kind_q == 2'h0 && (i_rpar !==
                    {^i_rdata[31:24], ^i_rdata[23:16], ^i_rdata[15:8], ^i_rdata[7:0]}));
                o_busy <= 1'b0;
                phase <= 2'h0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> bench/scr_backend_tb_top.sv
// self-checking bench for the scratchpad ram backend
`timescale 1ns/1ps
`default_nettype none
module scr_backend_tb_top;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic go = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [1:0] kind = 2'h0;
    logic [19:2] idx = 18'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] val = 32'h0;
    logic [31:0] hrdata, value, rdata, m_data;
    logic [19:2] index;
    logic [23:0] rtag, m_tag;
    logic [3:0] rpar;
    logic [1:0] hresp;
    logic hreadyout, rd, dwr, twr, hold, hit, ppres, busy, m_hit, perr;
    logic [31:0] mem [int];
    int n_errors = 0;
    int checks_done = 0;
    int stalls = 0;
    scr_backend dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
        .i_iside_index(index), .i_iside_read_strobe(rd), .i_iside_data_write_strobe(dwr),
        .i_iside_tag_write_strobe(twr), .i_iside_combined_value(value),
        .o_iside_hold_request(hold), .o_iside_hit(hit), .o_iside_read_data(rdata),
        .o_iside_read_parity(rpar), .o_iside_tag_read_value(rtag),
        .o_iside_parity_present(ppres));
    scr_core_model core (.i_clk(i_clk), .i_rstn(i_rstn), .i_go(go), .i_kind(kind),
        .i_idx(idx), .i_val(val), .i_hold(hold), .i_hit(hit), .i_rdata(rdata), .i_rpar(rpar),
        .i_rtag(rtag), .i_par_present(ppres), .o_index(index), .o_rd(rd), .o_dwr(dwr),
        .o_twr(twr), .o_value(value), .o_busy(busy), .o_hit(m_hit), .o_data(m_data),
        .o_tag(m_tag), .o_par_err(perr));
    initial begin
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) if (hold === 1'b1) stalls++;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rdv);
        @(posedge i_clk);
        hsel <= 1'b1;
        htrans <= scr_pkg::HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge i_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge i_clk); while (hreadyout !== 1'b1);
        rdv = hrdata;
        check({30'h0, hresp}, {30'h0, scr_pkg::HRESP_OKAY});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(a, 1'b1, d, x);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        ahb(a, 1'b0, 32'h0, x);
        check(x, exp);
    endtask
    task automatic core_op(input logic [1:0] k, input logic [19:2] i, input logic [31:0] v);
        @(posedge i_clk);
        go <= 1'b1;
        kind <= k;
        idx <= i;
        val <= v;
        do @(posedge i_clk); while (busy !== 1'b1);
        go <= 1'b0;
        do @(posedge i_clk); while (busy === 1'b1);
    endtask
    task automatic bd_wait();
        logic [31:0] s;
        s = 32'h0;
        for (int i = 0; i < 20 && !s[scr_pkg::ST_DONE_BIT]; i++) begin
            ahb(scr_pkg::OFF_STATUS, 1'b0, 32'h0, s);
        end
        check(s & 32'h3, 32'h2);
    endtask
    task automatic report_and_stop();
        if (n_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_clk);
        n_errors++;
        report_and_stop();
    end
    initial begin
        logic [31:0] base, d;
        int w;
        base = $urandom(32'hBFC4) & 32'h0;
        repeat (8) @(posedge i_clk);
        i_rstn <= 1'b1;
        check({31'h0, ppres}, 32'h0);
        rd_chk(scr_pkg::OFF_CTRL, 32'h0);
        rd_chk(scr_pkg::OFF_STATUS, 32'h0);
        rd_chk(8'h1C, 32'h0);
        base = {20'($urandom()), 12'h000};
        wr(scr_pkg::OFF_BASE, base);
        wr(scr_pkg::OFF_CTRL, 32'h3);
        rd_chk(scr_pkg::OFF_BASE, base);
        check({31'h0, ppres}, 32'h1);
        check({31'h0, scr_pkg::WORDS * 4 >= 4096}, 32'h1);
        for (int ln = 0; ln < 5; ln++) begin
            core_op(2'h0, {ln[15:0], 2'h0}, 32'h0);
            d = (ln == 0) ? {8'h0, base[31:10], 2'h1} : 32'h0;
            if (ln == 1) d = {8'h0, scr_pkg::REGION_LINES, 2'h0};
            check({8'h0, m_tag}, d);
        end
        core_op(2'h2, 18'h0, $urandom());
        wr(scr_pkg::OFF_CTRL, 32'h2);
        core_op(2'h0, 18'h0, base);
        check({8'h0, m_tag}, {8'h0, base[31:10], 2'h0});
        check({31'h0, m_hit}, 32'h0);
        wr(scr_pkg::OFF_CTRL, 32'h3);
        for (int n = 0; n < 16; n++) begin
            w = $urandom() % scr_pkg::WORDS;
            d = $urandom();
            mem[w] = d;
            core_op(2'h1, {8'h0, w[9:0]}, d);
            core_op(2'h0, {8'h0, w[9:0]}, base | (w << 2));
            check({31'h0, m_hit}, 32'h1);
            check(m_data, mem[w]);
            core_op(2'h0, {8'h0, w[9:0]}, base ^ 32'h0000_1000);
            check({31'h0, m_hit}, 32'h0);
        end
        check(stalls, 32'h0);
        check({31'h0, perr}, 32'h0);
        d = $urandom();
        mem[5] = d;
        wr(scr_pkg::OFF_BD_ADDR, 32'h14);
        wr(scr_pkg::OFF_BD_WDATA, d);
        wr(scr_pkg::OFF_BD_CMD, 32'h3);
        bd_wait();
        core_op(2'h0, 18'h5, base | 32'h14);
        check(m_data, d);
        for (int off = 0; off < 4; off++) begin
            fork
                wr(scr_pkg::OFF_BD_CMD, 32'h1);
                begin
                    repeat (off) @(posedge i_clk);
                    core_op(2'h0, {8'h0, w[9:0]}, base | (w << 2));
                end
            join
            check(m_data, mem[w]);
            bd_wait();
            rd_chk(scr_pkg::OFF_BD_RDATA, d);
        end
        check({31'h0, stalls != 0}, 32'h1);
        report_and_stop();
    end
endmodule
`default_nettype wire
